// ==== plb_logic.sv ====
// Basic logic gates, truth-table block and one generic special function behind classic Wishbone.
`timescale 1ns/1ps

// Behaviour
// - Edge NAND fires when all-high turns low.
// - Edge NAND pulse lasts one cycle only.
// - Unused edge NAND inputs count as one.
// - OR high when any input high.
// - NOR high only when all inputs low.
// - XOR high when two inputs differ.
// - Inverter outputs the complement of input.
// - Truth table has sixteen configurable entries.
// - Unconnected truth-table inputs read as zero.
// - Polarity option inverts truth-table output.
// - Writable entries follow the connected inputs.
// - Set input drives the output high.
// - Reset overrides everything and clears latch, count and output.
// - Enable low freezes the special function.
// - Invert input flips the block output.
// - Reset-all clears latch, count, timer and output; the hours counter keeps its value.
// - Count pulses, direction picks up/down.
// - Time base selects field units.
// - Timer deviation stays within tolerance.
// - Retentive state survives power loss.
// - Hours counter keeps its value except at rstn reset, which clears it.
// - Protection hides parameters outside programming mode.
module plb_logic #(
	parameter int CYCLE_CLKS = plb_pkg::PLB_CYCLE_CLKS,
	parameter int HUND_CLKS  = plb_pkg::PLB_HUND_CLKS
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Power loss indication from the supply monitor
	input  wire logic        pwr_loss,
	// Block outputs
	output logic             q_nand_edge,
	output logic             q_or,
	output logic             q_nor,
	output logic             q_xor,
	output logic             q_not,
	output logic             q_bool,
	output logic             q_sf
);
	import plb_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic                  pl_s1;
		logic                  pl_s2;
		logic [15:0]           cyc_cnt;
		logic [31:0]           hund_cnt;
		logic                  ack;
		logic [31:0]           rdat;
		logic [11:0]           gin;
		logic [11:0]           gcon;
		logic [15:0]           tab;
		logic                  pol;
		logic [10:0]           sfc;
		logic [17:0]           par;
		logic [15:0]           thr;
		logic                  prev_all;
		logic                  nand_e;
		logic                  q_or;
		logic                  q_nor;
		logic                  q_xor;
		logic                  q_not;
		logic                  q_bool;
		logic                  cnt_prev;
		logic                  trg_prev;
		logic                  latch;
		logic [PLB_CNT_W-1:0]  count;
		logic [PLB_TIME_W-1:0] remain;
		logic                  q_sf;
		logic [6:0]            hrs_frac;
		logic [31:0]           hrs;
	} plb_state_t;

	plb_state_t st_r;
	plb_state_t st_nxt;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] plb_time_hund(input logic [1:0] base, input logic [7:0] hi,
		input logic [7:0] lo);
		logic [31:0] h32;
		logic [31:0] l32;
		h32 = {24'h000000, hi};
		l32 = {24'h000000, lo};
		case (base)
			PLB_BASE_SEC: plb_time_hund = h32 * PLB_HUND_PER_SEC + l32;
			PLB_BASE_MIN: plb_time_hund = (h32 * PLB_SEC_PER_MIN + l32) * PLB_HUND_PER_SEC;
			PLB_BASE_HR:  plb_time_hund = (h32 * PLB_SEC_PER_MIN + l32) * PLB_HUND_PER_MIN;
			default:      plb_time_hund = 32'h0000_0000;
		endcase
	endfunction

	function automatic logic [31:0] plb_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		plb_merge = m;
	endfunction

	// ==========================================================
	// Combinational next state
	logic        req;
	logic        hidden;
	logic        tick;
	logic        hund;
	logic [3:0]  nand_in;
	logic [3:0]  or_in;
	logic [1:0]  xor_in;
	logic [3:0]  b_idx;
	logic [15:0] tab_wmask;
	logic [31:0] wv;
	logic        sf_clear;
	logic        q_raw;
	logic        en;

	always_comb begin
		st_nxt = st_r;
		wv = 32'h0000_0000;
		req = wb_cyc_i && wb_stb_i && !st_r.ack;
		// Protected parameters stay invisible unless programming mode is selected.
		hidden = st_r.sfc[PLB_SFC_PROT] && !st_r.sfc[PLB_SFC_PROG];
		tick = (st_r.cyc_cnt == 16'(CYCLE_CLKS - 1));
		// The 10 ms base comes from an exact but free-running divider, so the timer can lose up to one 10 ms step besides the clock error.
		hund = (st_r.hund_cnt == 32'(HUND_CLKS - 1));
		en = st_r.sfc[PLB_SFC_EN];

		st_nxt.pl_s1 = pwr_loss;
		st_nxt.pl_s2 = st_r.pl_s1;
		st_nxt.cyc_cnt = tick ? 16'h0000 : st_r.cyc_cnt + 16'h0001;
		st_nxt.hund_cnt = hund ? 32'h0000_0000 : st_r.hund_cnt + 32'h0000_0001;

		// Unused gate inputs are forced to the neutral value of each gate.
		nand_in = st_r.gin[PLB_GIN_GATE +: 4] | ~st_r.gcon[PLB_GIN_GATE +: 4];
		or_in = st_r.gin[PLB_GIN_GATE +: 4] & st_r.gcon[PLB_GIN_GATE +: 4];
		xor_in = st_r.gin[PLB_GIN_XOR +: 2] & st_r.gcon[PLB_GIN_XOR +: 2];
		b_idx = st_r.gin[PLB_GIN_BOOL +: 4] & st_r.gcon[PLB_GIN_BOOL +: 4];
		// An entry is writable only if its index uses no unconnected input.
		for (int i = 0; i < 16; i++) begin
			tab_wmask[i] = ((4'(i) & ~st_r.gcon[PLB_GIN_BOOL +: 4]) == 4'h0)
				&& (st_r.gcon[PLB_GIN_BOOL +: 4] != 4'h0);
		end

		// Wishbone: one registered answer per request after one wait cycle, dropped in the cycle after.
		st_nxt.ack = req;
		if (req && wb_we_i) begin
			wv = plb_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
			case (wb_adr_i)
				PLB_GIN_OFF:  st_nxt.gin = 12'(plb_merge({20'h00000, st_r.gin}, wb_dat_i, wb_sel_i));
				PLB_GCON_OFF: st_nxt.gcon = 12'(plb_merge({20'h00000, st_r.gcon}, wb_dat_i, wb_sel_i));
				PLB_BTAB_OFF: begin
					if (!hidden) begin
						wv = plb_merge({15'h0000, st_r.pol, st_r.tab}, wb_dat_i, wb_sel_i);
						st_nxt.tab = (st_r.tab & ~tab_wmask) | (wv[15:0] & tab_wmask);
						st_nxt.pol = wv[PLB_BTAB_POL];
					end
				end
				PLB_SFC_OFF:  st_nxt.sfc = 11'(plb_merge({21'h000000, st_r.sfc}, wb_dat_i, wb_sel_i));
				PLB_SFP_OFF: begin
					if (!hidden) begin
						st_nxt.par = 18'(plb_merge({14'h0000, st_r.par}, wb_dat_i, wb_sel_i));
					end
				end
				PLB_THR_OFF: begin
					if (!hidden) begin
						st_nxt.thr = 16'(plb_merge({16'h0000, st_r.thr}, wb_dat_i, wb_sel_i));
					end
				end
				default: st_nxt.gin = st_r.gin;
			endcase
		end
		st_nxt.rdat = 32'h0000_0000;
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				PLB_GIN_OFF:  st_nxt.rdat = {20'h00000, st_r.gin};
				PLB_GCON_OFF: st_nxt.rdat = {20'h00000, st_r.gcon};
				PLB_BTAB_OFF: st_nxt.rdat = hidden ? 32'h0000_0000 : {15'h0000, st_r.pol, st_r.tab};
				PLB_SFC_OFF:  st_nxt.rdat = {21'h000000, st_r.sfc};
				PLB_SFP_OFF:  st_nxt.rdat = hidden ? 32'h0000_0000 : {14'h0000, st_r.par};
				PLB_THR_OFF:  st_nxt.rdat = hidden ? 32'h0000_0000 : {16'h0000, st_r.thr};
				PLB_STAT_OFF: st_nxt.rdat = {st_r.count, 8'h00, 1'b0, st_r.q_sf, st_r.q_bool, st_r.q_not,
					st_r.q_xor, st_r.q_nor, st_r.q_or, st_r.nand_e};
				PLB_REM_OFF:  st_nxt.rdat = {5'h00, st_r.remain};
				PLB_HRS_OFF:  st_nxt.rdat = st_r.hrs;
				default:      st_nxt.rdat = 32'h0000_0000;
			endcase
		end

		// Gates advance once per program cycle.
		if (tick) begin
			st_nxt.prev_all = &nand_in;
			// Firing needs all-high last cycle, so the cycle after a pulse is always low.
			st_nxt.nand_e = st_r.prev_all && !(&nand_in);
			st_nxt.q_or = |or_in;
			st_nxt.q_nor = ~(|or_in);
			st_nxt.q_xor = xor_in[0] ^ xor_in[1];
			st_nxt.q_not = ~st_r.gin[PLB_GIN_NOT];
			st_nxt.q_bool = st_r.tab[b_idx] ^ st_r.pol;
		end

		// Special function: latch, up/down counter and a one-shot timer.
		q_raw = st_r.latch || (st_r.count >= st_r.thr);
		if (tick) begin
			st_nxt.cnt_prev = st_r.sfc[PLB_SFC_CNT];
			st_nxt.trg_prev = st_r.sfc[PLB_SFC_TRG];
			if (st_r.sfc[PLB_SFC_RST]) begin
				st_nxt.latch = 1'b0;
				st_nxt.count = '0;
				st_nxt.q_sf = 1'b0;
			end else if (en) begin
				if (st_r.sfc[PLB_SFC_SET]) begin
					st_nxt.latch = 1'b1;
				end
				if (st_r.sfc[PLB_SFC_CNT] && !st_r.cnt_prev) begin
					st_nxt.count = st_r.sfc[PLB_SFC_DIR] ? st_r.count - PLB_CNT_W'(1) : st_r.count + PLB_CNT_W'(1);
				end
				if (st_r.sfc[PLB_SFC_TRG] && !st_r.trg_prev) begin
					st_nxt.remain = PLB_TIME_W'(plb_time_hund(st_r.par[PLB_SFP_BASE +: 2], st_r.par[PLB_SFP_HI +: 8],
						st_r.par[PLB_SFP_LO +: 8]));
				end
				st_nxt.q_sf = (q_raw || st_r.sfc[PLB_SFC_SET]) ^ st_r.sfc[PLB_SFC_INV];
			end
		end
		if (hund && en && !st_r.sfc[PLB_SFC_RST] && st_r.remain != '0 && !(tick && st_nxt.remain != st_r.remain)) begin
			st_nxt.remain = st_r.remain - PLB_TIME_W'(1);
		end

		// Hours counter runs while the output is on and is never cleared by power loss.
		if (hund && st_r.q_sf) begin
			st_nxt.hrs_frac = (st_r.hrs_frac == 7'(PLB_HUND_PER_SECI - 1)) ? 7'h00 : st_r.hrs_frac + 7'h01;
			if (st_r.hrs_frac == 7'(PLB_HUND_PER_SECI - 1)) begin
				st_nxt.hrs = st_r.hrs + 32'h0000_0001;
			end
		end

		// A power loss wipes volatile state unless the function is set retentive.
		sf_clear = st_r.sfc[PLB_SFC_RAL] || (st_r.pl_s2 && !st_r.sfc[PLB_SFC_RET]);
		if (sf_clear) begin
			st_nxt.latch = 1'b0;
			st_nxt.count = '0;
			st_nxt.remain = '0;
			st_nxt.q_sf = 1'b0;
			st_nxt.cnt_prev = 1'b0;
			st_nxt.trg_prev = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign wb_ack_o    = st_r.ack;
	assign wb_dat_o    = st_r.rdat;
	assign q_nand_edge = st_r.nand_e;
	assign q_or        = st_r.q_or;
	assign q_nor       = st_r.q_nor;
	assign q_xor       = st_r.q_xor;
	assign q_not       = st_r.q_not;
	assign q_bool      = st_r.q_bool;
	assign q_sf        = st_r.q_sf;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	logic past_tick;
	always_ff @(posedge clock) begin
		if (!rstn) begin
			past_tick <= 1'b0;
		end else begin
			past_tick <= tick;
		end
	end

	nand_edge_fire_a: assert property (past_tick
		|-> q_nand_edge == ($past(st_r.prev_all) && !(&$past(nand_in))))
		else $error("edge nand output wrong");
	nand_pulse_len_a: assert property (past_tick && $past(q_nand_edge) |-> !q_nand_edge)
		else $error("edge nand pulse too long");
	nand_hold_a: assert property (!past_tick |-> $stable(q_nand_edge))
		else $error("edge nand output moved between cycles");
	nand_unused_a: assert property (&nand_in[3:0] || (|(~nand_in & st_r.gcon[3:0])) || st_r.gcon[3:0] == 4'hf)
		else $error("unused nand input not one");
	or_nor_pair_a: assert property (past_tick |-> q_or == ~q_nor && q_or == |$past(or_in))
		else $error("or nor mismatch");
	xor_not_a: assert property (past_tick |-> q_xor == ^$past(xor_in)
		&& q_not == !$past(st_r.gin[PLB_GIN_NOT]))
		else $error("xor or not wrong");
	bool_lookup_a: assert property (past_tick |-> q_bool == ($past(st_r.tab[b_idx]) ^ $past(st_r.pol)))
		else $error("truth table lookup wrong");
	tab_guard_a: assert property (st_r.gcon[11:8] == 4'h0 |=> $stable(st_r.tab))
		else $error("table changed with no inputs");
	rst_prio_a: assert property (tick && st_r.sfc[PLB_SFC_RST] |=> !q_sf && st_r.count == '0)
		else $error("reset did not clear");
	enable_hold_a: assert property (tick && !en && !sf_clear && !st_r.sfc[PLB_SFC_RST]
		|=> $stable(q_sf) && $stable(st_r.count))
		else $error("disabled function changed");
	set_out_a: assert property (tick && en && !st_r.sfc[PLB_SFC_RST] && !sf_clear && st_r.sfc[PLB_SFC_SET]
		|=> q_sf == !$past(st_r.sfc[PLB_SFC_INV]))
		else $error("set did not drive output");
	ral_clear_a: assert property (st_r.sfc[PLB_SFC_RAL] |=> st_r.count == '0 && st_r.remain == '0)
		else $error("reset all incomplete");
	retain_a: assert property (st_r.pl_s2 && st_r.sfc[PLB_SFC_RET] && !tick && !hund && !st_r.sfc[PLB_SFC_RAL]
		|=> $stable(st_r.count))
		else $error("retentive count lost");
	hours_keep_a: assert property (!hund |=> $stable(st_r.hrs))
		else $error("hours counter disturbed");
	prot_read_a: assert property (req && !wb_we_i && hidden && wb_adr_i == PLB_THR_OFF |=> wb_dat_o == 32'h0)
		else $error("protected parameter visible");

	bool_cov: cover property (past_tick && q_bool);
	nand_cov: cover property ($rose(q_nand_edge));
	count_cov: cover property (st_r.count == 16'h0003);
	prot_cov: cover property (req && hidden);
endmodule

// ==== plb_pkg.sv ====
// Package with register map, field layout and timing constants of the logic block set.
package plb_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] PLB_GIN_OFF  = 8'h00;
	localparam logic [7:0] PLB_GCON_OFF = 8'h04;
	localparam logic [7:0] PLB_BTAB_OFF = 8'h08;
	localparam logic [7:0] PLB_SFC_OFF  = 8'h0c;
	localparam logic [7:0] PLB_SFP_OFF  = 8'h10;
	localparam logic [7:0] PLB_THR_OFF  = 8'h14;
	localparam logic [7:0] PLB_STAT_OFF = 8'h18;
	localparam logic [7:0] PLB_REM_OFF  = 8'h1c;
	localparam logic [7:0] PLB_HRS_OFF  = 8'h20;
	// ==========================================================
	// Field positions
	localparam int PLB_GIN_GATE  = 0;
	localparam int PLB_GIN_XOR   = 4;
	localparam int PLB_GIN_NOT   = 6;
	localparam int PLB_GIN_BOOL  = 8;
	localparam int PLB_BTAB_POL  = 16;
	localparam int PLB_SFC_SET   = 0;
	localparam int PLB_SFC_RST   = 1;
	localparam int PLB_SFC_EN    = 2;
	localparam int PLB_SFC_INV   = 3;
	localparam int PLB_SFC_RAL   = 4;
	localparam int PLB_SFC_CNT   = 5;
	localparam int PLB_SFC_DIR   = 6;
	localparam int PLB_SFC_TRG   = 7;
	localparam int PLB_SFC_RET   = 8;
	localparam int PLB_SFC_PROT  = 9;
	localparam int PLB_SFC_PROG  = 10;
	localparam int PLB_SFP_LO    = 0;
	localparam int PLB_SFP_HI    = 8;
	localparam int PLB_SFP_BASE  = 16;
	localparam int PLB_STAT_CNT  = 16;
	// ==========================================================
	// Reset values and encodings
	localparam logic [31:0] PLB_ZERO_RST  = 32'h0000_0000;
	localparam logic [1:0]  PLB_BASE_SEC  = 2'h0;
	localparam logic [1:0]  PLB_BASE_MIN  = 2'h1;
	localparam logic [1:0]  PLB_BASE_HR   = 2'h2;
	localparam logic [31:0] PLB_HUND_PER_SEC  = 32'h0000_0064;
	localparam logic [31:0] PLB_SEC_PER_MIN   = 32'h0000_003c;
	localparam logic [31:0] PLB_HUND_PER_MIN  = 32'h0000_1770;
	// ==========================================================
	// Timing
	localparam int PLB_CLK_PERIOD_NS = 10;
	localparam int PLB_HUND_NS       = 10000000;
	localparam int PLB_HUND_CLKS     = PLB_HUND_NS / PLB_CLK_PERIOD_NS;
	localparam int PLB_CYCLE_CLKS    = 16;
	localparam int PLB_HUND_PER_SECI = 100;
	localparam int PLB_TIME_W        = 27;
	localparam int PLB_CNT_W         = 16;
endpackage

// ==== tb_plb_logic.sv ====
// Self-checking testbench of the logic block set.
`timescale 1ns/1ps

module tb_plb_logic;
	import plb_pkg::*;
	// ==========================================================
	// Signals
	// Short program cycle and 10 ms tick keep the run brief; waits built from C scale with it, the fixed counts do not.
	localparam int C = 4;
	localparam int S = 2 * C + 2;
	localparam logic [15:0] TAB = 16'h21f7;
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic        pwr_loss = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] dat_o;
	logic        ack;
	logic        q_ne, q_or, q_nor, q_xor, q_not, q_bool, q_sf;
	int          miscompares = 0;
	int          checks_done = 0;

	plb_logic #(.CYCLE_CLKS(C), .HUND_CLKS(20)) plb_logic_inst (
		.clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pwr_loss(pwr_loss),
		.q_nand_edge(q_ne), .q_or(q_or), .q_nor(q_nor), .q_xor(q_xor), .q_not(q_not),
		.q_bool(q_bool), .q_sf(q_sf));

	always #5 clock = ~clock;

	// ==========================================================
	// Bus cycles and comparison
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1);
		chk("ack", 32'(n), 32'h2);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic tk(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wt(input logic [7:0] a, input logic [31:0] d, input int n = S);
		logic [31:0] q;
		wb(1'b1, a, d, q);
		tk(n);
	endtask

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(nm, q & m, e);
	endtask

	task automatic pulses(input int e);
		int c;
		c = 0;
		repeat (4 * C) begin
			@(posedge clock);
			#1;
			if (q_ne === 1'b1) c++;
		end
		chk("pulse", c, e);
	endtask

	task automatic pwr;
		@(posedge clock);
		pwr_loss <= 1'b1;
		repeat (8) @(posedge clock);
		pwr_loss <= 1'b0;
		tk(8);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		logic [7:0] offs [9] = '{PLB_GIN_OFF, PLB_GCON_OFF, PLB_BTAB_OFF, PLB_SFC_OFF, PLB_SFP_OFF,
			PLB_THR_OFF, PLB_REM_OFF, PLB_HRS_OFF, 8'h40};
		chk("outs", 32'({q_ne, q_or, q_nor, q_xor, q_not, q_bool, q_sf}), 32'h14);
		wt(8'h40, 32'hffff_ffff);
		foreach (offs[i]) rc("reset", offs[i], 32'hffff_ffff, PLB_ZERO_RST);
	endtask

	task automatic t_gates;
		logic [3:0] v;
		wt(PLB_GCON_OFF, 32'h0000_0f3f);
		for (int i = 0; i < 16; i++) begin
			v = i[3:0];
			wt(PLB_GIN_OFF, {25'h0, v[0], v[1:0], v});
			chk("or", 32'(q_or), 32'(|v));
			chk("nor", 32'(q_nor), 32'(~|v));
			chk("xor", 32'(q_xor), 32'(^v[1:0]));
			chk("not", 32'(q_not), 32'(!v[0]));
		end
	endtask

	task automatic t_nand;
		wt(PLB_GIN_OFF, 32'h0000_000f);
		wt(PLB_GIN_OFF, 32'h0000_0007, 0);
		pulses(C);
		pulses(0);
		wt(PLB_GIN_OFF, 32'h0000_0003, 0);
		pulses(0);
	endtask

	task automatic t_bool;
		wt(PLB_GCON_OFF, 32'h0000_000f);
		wt(PLB_BTAB_OFF, 32'h0000_ffff);
		rc("tab", PLB_BTAB_OFF, 32'h0000_ffff, 32'h0);
		wt(PLB_GCON_OFF, 32'h0000_0100);
		wt(PLB_BTAB_OFF, {16'h0, TAB});
		rc("tab", PLB_BTAB_OFF, 32'h0000_ffff, 32'h0000_0003);
		wt(PLB_GCON_OFF, 32'h0000_0f00);
		for (int p = 0; p < 2; p++) begin
			wt(PLB_BTAB_OFF, {15'h0, p[0], TAB});
			for (int i = 0; i < 16; i++) begin
				wt(PLB_GIN_OFF, {20'h0, i[3:0], 8'h0});
				chk("bool", 32'(q_bool), 32'(TAB[i] ^ p[0]));
			end
		end
		rc("tab", PLB_BTAB_OFF, 32'hffff_ffff, {16'h1, TAB});
		wt(PLB_BTAB_OFF, {16'h0, TAB});
	endtask

	task automatic t_unused;
		wt(PLB_GCON_OFF, 32'h0000_0101);
		wt(PLB_GIN_OFF, 32'h0000_0e1e);
		chk("unused", 32'({q_or, q_nor, q_xor, q_bool}), 32'h5);
		wt(PLB_GIN_OFF, 32'h0000_0e01);
		wt(PLB_GIN_OFF, 32'h0000_0e00, 0);
		pulses(C);
	endtask

	// Each step writes the control word, then expects the count field and the output bit.
	task automatic t_sf;
		logic [31:0] sfc [15] = '{32'h04, 32'h24, 32'h04, 32'h24, 32'h04, 32'h64, 32'h44, 32'h21, 32'h01,
			32'h05, 32'h0d, 32'h14, 32'h04, 32'h05, 32'h07};
		logic [31:0] st [15] = '{32'h0, 32'h1_0000, 32'h1_0000, 32'h2_0040, 32'h2_0040, 32'h1_0000,
			32'h1_0000, 32'h1_0000, 32'h1_0000, 32'h1_0040, 32'h1_0000, 32'h0, 32'h0, 32'h40, 32'h0};
		wt(PLB_THR_OFF, 32'h0000_0002);
		foreach (sfc[i]) begin
			wt(PLB_SFC_OFF, sfc[i]);
			rc("sf", PLB_STAT_OFF, 32'hffff_0040, st[i]);
		end
		wt(PLB_SFC_OFF, 32'h0000_0200);
		wt(PLB_THR_OFF, 32'h0000_0005);
		rc("prot", PLB_THR_OFF, 32'hffff_ffff, 32'h0);
		wt(PLB_SFC_OFF, 32'h0000_0600);
		rc("prot", PLB_THR_OFF, 32'hffff_ffff, 32'h0000_0002);
	endtask

	task automatic t_time;
		logic [31:0] par [3] = '{32'h0000_0105, 32'h0001_0203, 32'h0002_0101};
		int e [3] = '{105, 12300, 366000};
		logic [31:0] q;
		wt(PLB_SFC_OFF, 32'h0000_0004);
		for (int b = 0; b < 3; b++) begin
			wt(PLB_SFP_OFF, par[b]);
			wt(PLB_SFC_OFF, 32'h0000_0084, C + 2);
			wt(PLB_SFC_OFF, 32'h0000_0004, 0);
			wb(1'b0, PLB_REM_OFF, 32'h0, q);
			// At most one 10 ms step can pass between loading and reading.
			chk("rem", 32'(q <= e[b] && q + 1 >= e[b]), 32'h1);
		end
	endtask

	task automatic t_power;
		wt(PLB_THR_OFF, 32'h0000_0005);
		wt(PLB_SFC_OFF, 32'h0000_0124);
		wt(PLB_SFC_OFF, 32'h0000_0104);
		pwr();
		rc("keep", PLB_STAT_OFF, 32'hffff_0000, 32'h0001_0000);
		wt(PLB_SFC_OFF, 32'h0000_0004);
		pwr();
		rc("lose", PLB_STAT_OFF, 32'hffff_0000, 32'h0);
		wt(PLB_SFC_OFF, 32'h0000_0005, 2100);
		pwr();
		rc("hours", PLB_HRS_OFF, 32'hffff_ffff, 32'h0000_0001);
	endtask

	// ==========================================================
	// Sequence and watchdog
	initial begin
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		tk(S);
		t_reset();
		t_gates();
		t_nand();
		t_bool();
		t_unused();
		t_sf();
		t_time();
		t_power();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		end_of_test();
	end
endmodule
